//--- inc/tsc_pkg.sv
// Purpose: Constants of the sample timestamp counter.
// Assumes: 32-bit classic Wishbone, word registers, index * 4 = byte address.
// Notes: Command values combine by OR; bit 0 is a one-shot command.
package tsc_pkg;
  // Register indices
  localparam logic [15:0] IDX_CMD = 16'hb798;
  localparam logic [15:0] IDX_AVAIL = 16'hb799;
  localparam logic [15:0] IDX_RST_TIME = 16'hb7b6;
  localparam logic [15:0] IDX_RST_DATE = 16'hb7b7;
  localparam logic [15:0] IDX_TIMEOUT = 16'hb7c5;
  localparam logic [15:0] IDX_STATUS = 16'hb7d0;
  localparam logic [15:0] IDX_STAMP_LO = 16'hb7d1;
  localparam logic [15:0] IDX_STAMP_HI = 16'hb7d2;
  localparam logic [15:0] IDX_HOST_TIME = 16'hb7d3;
  localparam logic [15:0] IDX_HOST_DATE = 16'hb7d4;
  localparam logic [15:0] IDX_CNT_LO = 16'hb7d5;
  localparam logic [15:0] IDX_CNT_HI = 16'hb7d6;
  // Command register values
  localparam logic [31:0] COUNTER_CLEAR_CMD = 32'h0000_0001;
  localparam logic [31:0] MODE_FREE_RUNNING = 32'h0000_0002;
  localparam logic [31:0] MODE_CLEAR_ON_START = 32'h0000_0004;
  localparam logic [31:0] SOURCE_SAMPLE_CLOCK = 32'h0000_0100;
  localparam logic [31:0] SOURCE_SPLIT_RISING = 32'h0000_0200;
  localparam logic [31:0] SOURCE_SPLIT_FALLING = 32'h0000_0400;
  localparam logic [31:0] AUX_INPUT_CAPTURE_ON = 32'h0000_1000;
  localparam logic [31:0] EXTRA_STAMP_FIRST_A_SAMPLE = 32'h0001_0000;
  localparam logic [31:0] CMD_STORE_MASK = 32'h0001_1706;
  localparam logic [31:0] AVAIL_MODES = 32'h0001_1706;
  // Field masks: time hh[23:16] mm[15:8] ss[7:0]; date yyyy[31:16]
  localparam logic [31:0] TIME_MASK = 32'h00ff_ffff;
  localparam logic [31:0] DATE_MASK = 32'hffff_ffff;
  // Reset values
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
  localparam logic [31:0] STAMP_TIME_RST = 32'h0000_0000;
  // Status bit positions
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_REF_TIMEOUT = 3;
  localparam int ST_COUNT_LSB = 8;
  // Widths
  localparam int STAMP_W = 64;
  localparam int SPLIT_W = 32;
  localparam int AUX_W = 8;
  localparam int FIFO_DEPTH = 16;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEOUT_UNIT_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;
endpackage : tsc_pkg

//--- hdl/tsc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter and edges.
// Assumes: Pins are asynchronous to clk.
// Notes: A bit changes only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic [W-1:0] pin_in, // Raw pin
  output logic [W-1:0] level_out, // Filtered level
  output logic [W-1:0] rise_out, // One-cycle rise pulse
  output logic [W-1:0] fall_out // One-cycle fall pulse
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, prev_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lvl_ff <= '0;
      prev_ff <= '0;
    end else begin
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
      prev_ff <= lvl_ff;
    end
  end

  assign level_out = lvl_ff;
  assign rise_out = lvl_ff & ~prev_ff;
  assign fall_out = ~lvl_ff & prev_ff;
endmodule : tsc_sync
`default_nettype wire

//--- hdl/tsc_fifo.sv
// Purpose: Timestamp FIFO held in flip-flops.
// Assumes: Caller may push while full; such a push is dropped, not stored.
// Notes: First in, first out; no bypass, one cycle to show a new head.
`timescale 1ns/1ps
`default_nettype none
module tsc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic push_valid, // Store push_data
  input wire logic [W-1:0] push_data, // Stamp in
  output logic push_ready, // Not full
  input wire logic pop_ready, // Drop head
  output logic pop_valid, // Not empty
  output logic [W-1:0] pop_data, // Head stamp
  output logic [CW-1:0] count // Entries held
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff, rd_ff;
  logic [CW-1:0] cnt_ff;
  logic do_push, do_pop;

  assign push_ready = (cnt_ff != CW'(DEPTH));
  assign pop_valid = (cnt_ff != '0);
  assign do_push = push_valid && push_ready;
  assign do_pop = pop_ready && pop_valid;
  assign pop_data = mem_ff[rd_ff];
  assign count = cnt_ff;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : wrap_inc

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_ff[wr_ff] <= push_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) wr_ff <= wrap_inc(wr_ff);
      if (do_pop) rd_ff <= wrap_inc(rd_ff);
      cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : tsc_fifo
`default_nettype wire

//--- hdl/tsc_top.sv
// Purpose: Sample timestamp counter with stamp FIFO, Wishbone registers.
// Assumes: sample_tick pulses once per sample on clk; event inputs are
//   one-cycle pulses from logic on clk; ref clock and aux are pins.
// Notes: One stamp per cycle; simultaneous events share one stamp.
// Operation
// - Counter advances once per sample tick
// - Cleared by command or card start
// - Trigger pushes counter value into FIFO
// - Gate open and close each push stamp
// - Stamps are raw sample counts
// - Reset time: hours, minutes, seconds fields
// - Reset date: year, month, day fields
// - Timeout in ms for reference edge
// - Read-only bitmap of supported modes
// - Mode 0 off, 2h free, 4h start-clear
// - Command 1h clears, latches host time
// - 100h: single full-width sample counter
// - 200h: split, upper on reference rise
// - 400h: split, upper on reference fall
// - 1000h: aux inputs in upper byte
// - Aux off: upper bits hold the counter
// - 10000h: extra stamp, first A sample
// - Clear command ignored without active clock generation
// - Every stamp is 64 bits wide
// - Free mode runs regardless of acquisitions
// - Reference edge clears lower, bumps upper
// - Clear zeroes both split halves
`timescale 1ns/1ps
`default_nettype none
module tsc_top
  import tsc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // 40 MHz clock
  input wire logic reset, // Async reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [17:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic sample_tick, // One pulse per sample
  input wire logic clock_gen_active, // Sampling clock running
  input wire logic card_start, // Acquisition start pulse
  input wire logic trigger_event, // Trigger pulse
  input wire logic gate_open, // Gate start pulse
  input wire logic gate_close, // Gate end pulse
  input wire logic first_a_sample, // First A-area sample pulse
  input wire logic ref_clock_pin, // External reference clock
  input wire logic [AUX_W-1:0] aux_in_pin // Auxiliary inputs
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [31:0] cmd_ff, rst_time_ff, rst_date_ff, timeout_ff;
  logic [31:0] host_time_ff, host_date_ff, rdata;
  logic [STAMP_W-1:0] cnt_ff, stamp_w, head;
  logic [AUX_W-1:0] aux_lvl;
  logic ack_ff, ovf_ff, tmo_flag_ff;
  logic [31:0] dat_ff;
  logic ref_rise, ref_fall, ref_edge;
  logic take, wr, rd;
  logic [15:0] idx;
  logic mode_on, split, clr_cmd, clr_ok, clr_now, push_w, pop_w;
  logic f_ready, f_valid;
  logic [CW-1:0] f_count;
  // Wide enough to hold MS_CYC itself, so a tiny sim divider still fits
  localparam int MDW = $clog2(MS_CYC + 1);
  logic [MDW-1:0] ms_div_ff;
  logic [31:0] ms_elapsed_ff;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic hit(input logic [15:0] a, input logic [15:0] i);
    return a == i;
  endfunction : hit

  tsc_sync #(.W(1)) u_ref_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(ref_clock_pin),
    .level_out(),
    .rise_out(ref_rise),
    .fall_out(ref_fall)
  );

  tsc_sync #(.W(AUX_W)) u_aux_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(aux_in_pin),
    .level_out(aux_lvl),
    .rise_out(),
    .fall_out()
  );

  // Bus decode; answer comes one cycle after the request is seen
  // ack_ff blocks a retake in the ack cycle; the master must drop stb
  assign idx = wb_adr_i[17:2];
  assign take = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr = take && wb_we_i;
  assign rd = take && !wb_we_i;

  // Command decode
  assign mode_on = |(cmd_ff & (MODE_FREE_RUNNING | MODE_CLEAR_ON_START));
  assign split = |(cmd_ff & (SOURCE_SPLIT_RISING | SOURCE_SPLIT_FALLING));
  assign ref_edge = (|(cmd_ff & SOURCE_SPLIT_RISING) && ref_rise)
                 || (|(cmd_ff & SOURCE_SPLIT_FALLING) && ref_fall);
  assign clr_cmd = wr && hit(idx, IDX_CMD) && wb_sel_i[0]
                && |(wb_dat_i & COUNTER_CLEAR_CMD);
  assign clr_ok = clr_cmd && clock_gen_active;
  assign clr_now = clr_ok
                || (|(cmd_ff & MODE_CLEAR_ON_START) && card_start);

  // Capture: trigger, gate edges, optional first A-area sample
  assign push_w = mode_on && (trigger_event
                || gate_open || gate_close
                || (|(cmd_ff & EXTRA_STAMP_FIRST_A_SAMPLE)
                    && first_a_sample));
  assign stamp_w = |(cmd_ff & AUX_INPUT_CAPTURE_ON)
                 ? {aux_lvl, cnt_ff[STAMP_W-AUX_W-1:0]}
                 : cnt_ff;
  assign pop_w = rd && hit(idx, IDX_STAMP_HI) && f_valid;

  tsc_fifo #(.W(STAMP_W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .push_valid(push_w),
    .push_data(stamp_w),
    .push_ready(f_ready),
    .pop_ready(pop_w),
    .pop_valid(f_valid),
    .pop_data(head),
    .count(f_count)
  );

  // Counter; holds while timestamping is off, except that a clear command still zeroes it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (clr_now) begin
      cnt_ff <= '0;
    end else if (mode_on && split) begin
      if (ref_edge) begin
        cnt_ff[STAMP_W-1:SPLIT_W] <= cnt_ff[STAMP_W-1:SPLIT_W]
                                     + (STAMP_W-SPLIT_W)'(1);
        cnt_ff[SPLIT_W-1:0] <= '0;
      end else if (sample_tick) begin
        cnt_ff[SPLIT_W-1:0] <= cnt_ff[SPLIT_W-1:0] + SPLIT_W'(1);
      end
    end else if (mode_on && sample_tick) begin
      cnt_ff <= cnt_ff + STAMP_W'(1);
    end
  end

  // Command, timeout and host time registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_ff <= CMD_RST;
      timeout_ff <= TIMEOUT_RST;
      host_time_ff <= STAMP_TIME_RST;
      host_date_ff <= STAMP_TIME_RST;
    end else if (wr) begin
      if (hit(idx, IDX_CMD))
        cmd_ff <= merge(cmd_ff, wb_dat_i, wb_sel_i) & CMD_STORE_MASK;
      if (hit(idx, IDX_TIMEOUT))
        timeout_ff <= merge(timeout_ff, wb_dat_i, wb_sel_i);
      if (hit(idx, IDX_HOST_TIME))
        host_time_ff <= merge(host_time_ff, wb_dat_i, wb_sel_i) & TIME_MASK;
      if (hit(idx, IDX_HOST_DATE))
        host_date_ff <= merge(host_date_ff, wb_dat_i, wb_sel_i) & DATE_MASK;
    end
  end

  // Reset time and date; a clear command latches the host's clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_time_ff <= STAMP_TIME_RST;
      rst_date_ff <= STAMP_TIME_RST;
    end else if (clr_ok) begin
      rst_time_ff <= host_time_ff;
      rst_date_ff <= host_date_ff;
    end else if (wr) begin
      if (hit(idx, IDX_RST_TIME))
        rst_time_ff <= merge(rst_time_ff, wb_dat_i, wb_sel_i) & TIME_MASK;
      if (hit(idx, IDX_RST_DATE))
        rst_date_ff <= merge(rst_date_ff, wb_dat_i, wb_sel_i) & DATE_MASK;
    end
  end

  // Reference edge watchdog in ms; zero timeout disables it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_div_ff <= '0;
      ms_elapsed_ff <= '0;
    end else if (!(mode_on && split) || ref_edge || clr_now) begin
      ms_div_ff <= '0;
      ms_elapsed_ff <= '0;
    end else if (ms_div_ff == MDW'(MS_CYC - 1)) begin
      ms_div_ff <= '0;
      // Saturates so a long silence cannot wrap into a false match
      if (ms_elapsed_ff != '1) ms_elapsed_ff <= ms_elapsed_ff + 32'h1;
    end else begin
      ms_div_ff <= ms_div_ff + MDW'(1);
    end
  end

  // Sticky status flags; a new event wins over write-one-to-clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_ff <= 1'b0;
      tmo_flag_ff <= 1'b0;
    end else begin
      if (push_w && !f_ready)
        ovf_ff <= 1'b1;
      else if (wr && hit(idx, IDX_STATUS) && wb_sel_i[0]
               && wb_dat_i[ST_OVERFLOW])
        ovf_ff <= 1'b0;
      if (timeout_ff != '0 && ms_elapsed_ff == timeout_ff)
        tmo_flag_ff <= 1'b1;
      else if (wr && hit(idx, IDX_STATUS) && wb_sel_i[0]
               && wb_dat_i[ST_REF_TIMEOUT])
        tmo_flag_ff <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0;
    unique case (idx)
      IDX_CMD: rdata = cmd_ff;
      IDX_AVAIL: rdata = AVAIL_MODES;
      IDX_RST_TIME: rdata = rst_time_ff;
      IDX_RST_DATE: rdata = rst_date_ff;
      IDX_TIMEOUT: rdata = timeout_ff;
      IDX_STATUS: begin
        rdata[ST_EMPTY] = !f_valid;
        rdata[ST_FULL] = !f_ready;
        rdata[ST_OVERFLOW] = ovf_ff;
        rdata[ST_REF_TIMEOUT] = tmo_flag_ff;
        rdata[ST_COUNT_LSB +: CW] = f_count;
      end
      IDX_STAMP_LO: rdata = head[31:0];
      IDX_STAMP_HI: rdata = head[63:32];
      IDX_HOST_TIME: rdata = host_time_ff;
      IDX_HOST_DATE: rdata = host_date_ff;
      IDX_CNT_LO: rdata = cnt_ff[31:0];
      IDX_CNT_HI: rdata = cnt_ff[63:32];
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= take;
      dat_ff <= rd ? rdata : 32'h0;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_count_step: assert property (
    (mode_on && !split && sample_tick && !clr_now)
      |=> cnt_ff == $past(cnt_ff) + 64'h1)
    else $error("counter did not advance on sample tick");
  chk_clear_cmd: assert property (
    clr_ok |=> cnt_ff == 64'h0 && rst_date_ff == $past(host_date_ff))
    else $error("clear command did not clear or latch date");
  chk_clear_ignored: assert property (
    (clr_cmd && !clock_gen_active) |=> $stable(rst_time_ff))
    else $error("clear acted without clock generation");
  chk_start_clear: assert property (
    (|(cmd_ff & MODE_CLEAR_ON_START) && card_start) |=> cnt_ff == 64'h0)
    else $error("card start did not clear counter");
  chk_push_count: assert property (
    (trigger_event && mode_on && f_ready && !pop_w)
      |=> f_count == $past(f_count) + 1'b1)
    else $error("trigger did not store a stamp");
  // Stamp checks watch the head, so they need an empty FIFO first
  chk_aux_off: assert property (
    (push_w && !f_valid && !(|(cmd_ff & AUX_INPUT_CAPTURE_ON)))
      |=> head == $past(cnt_ff))
    else $error("stored stamp differs from counter with aux off");
  chk_aux_byte: assert property (
    (push_w && !f_valid && |(cmd_ff & AUX_INPUT_CAPTURE_ON))
      |=> head[63:56] == $past(aux_lvl)
          && head[55:0] == $past(cnt_ff[55:0]))
    else $error("aux byte missing from stored stamp");
  chk_ref_edge: assert property (
    (mode_on && split && ref_edge && !clr_now)
      |=> cnt_ff[31:0] == 32'h0
          && cnt_ff[63:32] == $past(cnt_ff[63:32]) + 32'h1)
    else $error("reference edge did not split-step counter");
  chk_mode_off: assert property (
    (!mode_on && !pop_w) |=> f_count == $past(f_count))
    else $error("stamp stored while disabled");
  chk_mode_hold: assert property (
    (!mode_on && !clr_now) |=> $stable(cnt_ff))
    else $error("counter moved while disabled");
  chk_split_tick: assert property (
    (mode_on && split && sample_tick && !ref_edge && !clr_now)
      |=> cnt_ff[31:0] == $past(cnt_ff[31:0]) + 32'h1
          && cnt_ff[63:32] == $past(cnt_ff[63:32]))
    else $error("split counter low part did not step");
  chk_tmo_flag: assert property (
    (timeout_ff != 32'h0 && ms_elapsed_ff == timeout_ff) |=> tmo_flag_ff)
    else $error("reference timeout flag not raised");
  chk_ovf_flag: assert property (
    (push_w && !f_ready) |=> ovf_ff)
    else $error("overflow flag not raised on dropped stamp");
  chk_bus_ack: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  cov_aux_stamp: cover property (push_w && |(cmd_ff & AUX_INPUT_CAPTURE_ON));
  cov_split_edge: cover property (mode_on && split && ref_edge);
  cov_clear_ok: cover property (clr_ok);
  cov_fifo_full: cover property (!f_ready ##1 pop_w);
  cov_overflow: cover property (push_w && !f_ready);
endmodule : tsc_top
`default_nettype wire

//--- sim/tsc_far_model.sv
// Purpose: Far side of the stamp counter: ticks, clock generation, pins.
// Assumes: Bench changes inputs just after a rising edge.
// Notes: Ticks come only in loaded bursts, so sample counts stay exact.
`timescale 1ns/1ps
`default_nettype none
module tsc_far_model (
  input wire logic clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic load, // Take burst_len
  input wire logic [7:0] burst_len, // Ticks to emit
  input wire logic setup_req, // Write-setup command
  input wire logic ref_lvl, // Reference clock level
  input wire logic [7:0] aux_val, // Aux value
  output logic sample_tick, // One pulse per sample
  output logic clock_gen_active, // Generation running
  output logic ref_clock_pin, // Reference clock pin
  output logic [7:0] aux_in_pin // Aux pins
);
  logic [7:0] left_ff;
  logic gen_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left_ff <= 8'h00;
    end else if (load) begin
      left_ff <= burst_len;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
  // Generation starts only once setup was sent; clears are held off before
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gen_ff <= 1'b0;
    end else if (setup_req) begin
      gen_ff <= 1'b1;
    end
  end
  assign sample_tick = (left_ff != 8'h00);
  assign clock_gen_active = gen_ff;
  assign ref_clock_pin = ref_lvl;
  assign aux_in_pin = aux_val;
endmodule : tsc_far_model
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the sample timestamp counter.
// Assumes: Registers reached by classic Wishbone; ticks only in bursts.
// Notes: Events are sent with ticks stopped, so stamps are exact.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tsc_pkg::*;
;
  logic clk, reset, cyc, stb, we, ack, load, setup, refl;
  logic tick, gen, refp;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [4:0] ev;
  logic [7:0] blen, auxv, auxp;
  int err_count, tests_run, cyc_n;
  localparam logic [31:0] MODE_OFF_VALUE = 32'h0000_0000;

  tsc_far_model far (.clk(clk), .reset(reset), .load(load),
    .burst_len(blen), .setup_req(setup), .ref_lvl(refl), .aux_val(auxv),
    .sample_tick(tick), .clock_gen_active(gen), .ref_clock_pin(refp),
    .aux_in_pin(auxp));
  tsc_top #(.MS_CYC(10), .DEPTH(16)) dut (.clk(clk), .reset(reset),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .sample_tick(tick), .clock_gen_active(gen), .card_start(ev[4]),
    .trigger_event(ev[0]), .gate_open(ev[1]), .gate_close(ev[2]),
    .first_a_sample(ev[3]), .ref_clock_pin(refp), .aux_in_pin(auxp));

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dw <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic ticks(input int n);
    @(posedge clk);
    load <= 1'b1;
    blen <= n[7:0];
    @(posedge clk);
    load <= 1'b0;
    repeat (n + 2) @(posedge clk);
  endtask : ticks

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
    @(posedge clk);
  endtask : pulse

  task automatic refset(input logic v);
    @(posedge clk);
    refl <= v;
    repeat (8) @(posedge clk);
  endtask : refset

  task automatic stamp(input logic [31:0] lo, input logic [31:0] hi);
    rd_chk(IDX_STAMP_LO, lo);
    rd_chk(IDX_STAMP_HI, hi);
  endtask : stamp

  task automatic t_regs();
    rd_chk(IDX_CMD, 32'h0000_0000);
    rd_chk(IDX_AVAIL, 32'h0001_1706);
    wr(IDX_AVAIL, 32'h0000_0000);
    rd_chk(IDX_AVAIL, 32'h0001_1706);
    wr(IDX_TIMEOUT, 32'h0000_0005);
    rd_chk(IDX_TIMEOUT, 32'h0000_0005);
    wr(IDX_RST_TIME, 32'hff17_2b3c);
    rd_chk(IDX_RST_TIME, 32'h0017_2b3c);
    wr(IDX_RST_DATE, 32'h07e4_0c1f);
    rd_chk(IDX_RST_DATE, 32'h07e4_0c1f);
    wr(16'hb7ff, 32'h1234_5678);
    rd_chk(16'hb7ff, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_clear();
    wr(IDX_HOST_TIME, 32'h0001_0203);
    wr(IDX_HOST_DATE, 32'h07e5_0102);
    wr(IDX_CMD, MODE_FREE_RUNNING | SOURCE_SAMPLE_CLOCK);
    ticks(7);
    rd_chk(IDX_CNT_LO, 32'h0000_0007);
    wr(IDX_CMD, 32'h0000_0103);
    rd_chk(IDX_CNT_LO, 32'h0000_0007);
    rd_chk(IDX_RST_TIME, 32'h0017_2b3c);
    @(posedge clk);
    setup <= 1'b1;
    wr(IDX_CMD, 32'h0000_0103);
    rd_chk(IDX_CNT_LO, 32'h0000_0000);
    rd_chk(IDX_RST_TIME, 32'h0001_0203);
    rd_chk(IDX_RST_DATE, 32'h07e5_0102);
    rd_chk(IDX_CMD, 32'h0000_0102);
    $display("test clear done");
  endtask : t_clear

  task automatic t_stamps();
    ticks(5);
    pulse(0);
    ticks(3);
    pulse(1);
    ticks(2);
    pulse(2);
    rd_chk(IDX_STATUS, 32'h0000_0300);
    stamp(32'h0000_0005, 32'h0000_0000);
    stamp(32'h0000_0008, 32'h0000_0000);
    stamp(32'h0000_000a, 32'h0000_0000);
    rd_chk(IDX_STATUS, 32'h0000_0001);
    pulse(4);
    rd_chk(IDX_CNT_LO, 32'h0000_000a);
    $display("test stamps done");
  endtask : t_stamps

  task automatic t_modes();
    wr(IDX_CMD, MODE_OFF_VALUE);
    ticks(4);
    pulse(0);
    rd_chk(IDX_CNT_LO, 32'h0000_000a);
    rd_chk(IDX_STATUS, 32'h0000_0001);
    wr(IDX_CMD, MODE_CLEAR_ON_START | SOURCE_SAMPLE_CLOCK);
    pulse(4);
    rd_chk(IDX_CNT_LO, 32'h0000_0000);
    ticks(2);
    pulse(3);
    rd_chk(IDX_STATUS, 32'h0000_0001);
    wr(IDX_CMD, 32'h0001_0104);
    pulse(3);
    stamp(32'h0000_0002, 32'h0000_0000);
    $display("test modes done");
  endtask : t_modes

  task automatic t_aux();
    @(posedge clk);
    auxv <= 8'ha5;
    wr(IDX_CMD, 32'h0000_1102);
    pulse(0);
    stamp(32'h0000_0002, 32'ha500_0000);
    wr(IDX_CMD, 32'h0000_0102);
    pulse(0);
    stamp(32'h0000_0002, 32'h0000_0000);
    $display("test aux done");
  endtask : t_aux

  task automatic t_split();
    wr(IDX_CMD, 32'h0000_0203);
    ticks(4);
    rd_chk(IDX_CNT_LO, 32'h0000_0004);
    refset(1'b1);
    rd_chk(IDX_CNT_HI, 32'h0000_0001);
    rd_chk(IDX_CNT_LO, 32'h0000_0000);
    refset(1'b0);
    rd_chk(IDX_CNT_HI, 32'h0000_0001);
    wr(IDX_CMD, 32'h0000_0402);
    refset(1'b1);
    rd_chk(IDX_CNT_HI, 32'h0000_0001);
    refset(1'b0);
    rd_chk(IDX_CNT_HI, 32'h0000_0002);
    ticks(3);
    pulse(0);
    stamp(32'h0000_0003, 32'h0000_0002);
    wr(IDX_CMD, 32'h0000_0403);
    rd_chk(IDX_CNT_HI, 32'h0000_0000);
    rd_chk(IDX_CNT_LO, 32'h0000_0000);
    repeat (80) @(posedge clk);
    rd_chk(IDX_STATUS, 32'h0000_0009);
    $display("test split done");
  endtask : t_split

  task automatic t_full();
    for (int i = 0; i < 17; i++) begin
      ticks(1);
      pulse(0);
    end
    rd_chk(IDX_STATUS, 32'h0000_100e);
    wr(IDX_STATUS, 32'h0000_000c);
    rd_chk(IDX_STATUS, 32'h0000_1002);
    for (int i = 0; i < 16; i++) begin
      stamp(i + 1, 32'h0000_0000);
    end
    rd_chk(IDX_STATUS, 32'h0000_0001);
    $display("test full done");
  endtask : t_full

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {cyc, stb, we, load, setup, refl} = 6'h00;
    adr = 18'h00000;
    sel = 4'hf;
    dw = 32'h0000_0000;
    ev = 5'h00;
    blen = 8'h00;
    auxv = 8'h00;
    err_count = 0;
    tests_run = 0;
    cyc_n = 0;
    reset = 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_clear();
    t_stamps();
    t_modes();
    t_aux();
    t_split();
    t_full();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
